/* File: include/parallel_port_defines.vh */
// Purpose: Shared offsets, field positions, reset values and timing counts of the parallel port.
// Assumes: Byte addresses on a plain register port with 32-bit read and write data.
// Notes: Included by its bare name.
`ifndef PARALLEL_PORT_DEFINES_VH
`define PARALLEL_PORT_DEFINES_VH

// ============================================================
// Register offsets
`define OFS_CONTROL_ONE 8'h00
`define OFS_WIDTH_CFG   8'h04
`define OFS_ADDRESS     8'h08
`define OFS_WRITE_START 8'h0C
`define OFS_READ_START  8'h10
`define OFS_READ_DATA   8'h14
`define OFS_STATUS      8'h18
`define OFS_RBUF_BASE   8'h20
`define OFS_WBUF_BASE   8'h30
`define OFS_IRQ_STATUS  8'h40
`define OFS_IRQ_CLEAR   8'h44
`define OFS_IRQ_ENABLE  8'h48

// ============================================================
// Control one field positions
`define CTL_ENABLE     15
`define CTL_STOP_IDLE  13
`define CTL_MUX_HI     12
`define CTL_MUX_LO     11
`define CTL_MODE_HI    9
`define CTL_MODE_LO    8
`define CTL_CSF_HI     7
`define CTL_CSF_LO     6
`define CTL_ALP        5
`define CTL_LATCH_STROBE_STYLE     4
`define CTL_BUS_HOLD_ENABLE    2
`define CTL_IRQ_MODE_SELECT_HI    1
`define CTL_IRQ_MODE_SELECT_LO    0
`define CTL_WMASK      16'hBBF7

// ============================================================
// Reset values and codes
`define CONTROL_RESET  16'h0000
`define WIDTH_RESET    2'h0
`define MODE_LEGACY    2'h0
`define MODE_BUFFERED  2'h1
`define MODE_ENHANCED  2'h2
`define MODE_MASTER    2'h3
`define IRQ_BITS       2
`define IRQ_TRANSFER   0
`define IRQ_MASTER     1

// ============================================================
// Timing
`define PHASE_CYCLES   3'h4

`endif

/* File: design/sync2.v */
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clock_in.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         clock_in,
	input  wire         resetn_in,
	// Data
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

reg [W-1:0] stage_one;

always @(posedge clock_in or negedge resetn_in)
begin
	if (!resetn_in)
	begin
		stage_one <= {W{1'b0}};
		sync_out  <= {W{1'b0}};
	end
	else
	begin
		stage_one <= async_in;
		sync_out  <= stage_one;
	end
end

endmodule // sync2

`default_nettype wire

/* File: design/irq_block.v */
// Purpose: Sticky interrupt status with enable mask and write-one-to-clear.
// Assumes: Events are one-cycle pulses on clock_in.
// Notes: A set in the same cycle as its clear wins.
`timescale 1ns/10ps
`default_nettype none

module irq_block #(
	parameter N = 2
) (
	// Clock and reset
	input  wire         clock_in,
	input  wire         resetn_in,
	// Events and software access
	input  wire [N-1:0] event_in,
	input  wire         clear_write_in,
	input  wire         enable_write_in,
	input  wire [N-1:0] wdata_in,
	// State
	output reg  [N-1:0] status_out,
	output reg  [N-1:0] enable_out,
	output wire         irq_out
);

always @(posedge clock_in or negedge resetn_in)
begin
	if (!resetn_in)
	begin
		status_out <= {N{1'b0}};
		enable_out <= {N{1'b0}};
	end
	else
	begin
		status_out <= event_in | (status_out & ~({N{clear_write_in}} & wdata_in));
		if (enable_write_in)
			enable_out <= wdata_in;
	end
end

assign irq_out = |(status_out & enable_out);

endmodule // irq_block

`default_nettype wire

/* File: design/parallel_port_addr_mux.v */
// Purpose: Address/data multiplexing and strobe control of a parallel master/slave port.
// Assumes: One clock; host pins are asynchronous and pass sync2 first.
// Notes: Registers on a plain port; read data stand one cycle after the read strobe.
// What this block does
// - Mux select 00 puts address on address pins, data on data lines.
// - Mux select 01 sends low address byte with low latch strobe, then data.
// - Mux 10, 8-bit: low byte, high byte with their strobes, then data.
// - Width 00 moves each data item on all eight data lines.
// - Width 01 uses four data lines in master transfers; address phases carry nibbles, except the mux 01 low byte, sent whole on all eight lines.
// - Chip-select code 01 is reserved; code 00 makes the pin chip select one.
// - Enhanced slave mode lets the host reach buffers by strobes and two address lines.
// - Interrupt mode 11 fires on buffer 3 access or address 11 access.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "parallel_port_defines.vh"

module parallel_port_addr_mux (
	// Clock and reset
	input  wire        clock_in,
	input  wire        resetn_in,
	// Register port
	input  wire [7:0]  reg_addr_in,
	input  wire [31:0] reg_wdata_in,
	input  wire        reg_write_in,
	input  wire        reg_read_in,
	output reg  [31:0] reg_rdata_out,
	// Address and data pins
	output reg  [15:0] address_lines_out,
	output reg         address_lines_oe_out,
	input  wire [1:0]  address_lines_in,
	output reg  [7:0]  data_lines_out,
	output reg  [7:0]  data_lines_oe_out,
	input  wire [7:0]  data_lines_in,
	// Strobe pins
	output reg         addr_latch_low_strobe_out,
	output reg         addr_latch_high_strobe_out,
	output reg         addr_latch_upper_strobe_out,
	output reg         chip_select_pin_out,
	output reg         read_strobe_pin_out,
	output reg         write_strobe_pin_out,
	output reg         strobe_pins_oe_out,
	input  wire        chip_select_pin_in,
	input  wire        read_strobe_pin_in,
	input  wire        write_strobe_pin_in,
	// Interrupt
	output wire        irq_out
);

// ============================================================
// States
localparam S_IDLE  = 3'd0;
localparam S_LOW   = 3'd1;
localparam S_HIGH  = 3'd2;
localparam S_UPPER = 3'd3;
localparam S_DATA  = 3'd4;

reg [15:0] control_one;
reg [1:0]  port_width_select;
reg [22:0] address;
reg [7:0]  write_data;
reg [7:0]  read_capture;
reg        is_read;
reg [2:0]  state;
reg [2:0]  phase_count;
reg [7:0]  last_low;
reg [7:0]  last_high;
reg [7:0]  last_upper;
reg        last_valid;
reg [2:0]  skip_held;
reg [7:0]  read_buffer [0:3];
reg [7:0]  write_buffer [0:3];
reg [1:0]  read_ptr;
reg [1:0]  write_ptr;
reg        host_rd_prev;
reg        host_wr_prev;

wire [12:0] synced;
wire        host_cs = synced[12];
wire        host_rd = synced[11] & host_cs;
wire        host_wr = synced[10] & host_cs;
wire [1:0]  host_addr = synced[9:8];
wire [7:0]  host_data = synced[7:0];

wire        enabled = control_one[`CTL_ENABLE];
wire [1:0]  addr_mux_select = control_one[`CTL_MUX_HI:`CTL_MUX_LO];
wire [1:0]  slave_port_mode = control_one[`CTL_MODE_HI:`CTL_MODE_LO];
wire [1:0]  chip_select_function = control_one[`CTL_CSF_HI:`CTL_CSF_LO];
wire        latch_strobe_polarity = control_one[`CTL_ALP];
wire        latch_strobe_style = control_one[`CTL_LATCH_STROBE_STYLE];
wire        bus_hold_enable = control_one[`CTL_BUS_HOLD_ENABLE];
wire [1:0]  irq_mode_select = control_one[`CTL_IRQ_MODE_SELECT_HI:`CTL_IRQ_MODE_SELECT_LO];
wire        is_master = enabled & (slave_port_mode == `MODE_MASTER);
wire        wide = (port_width_select == 2'h0);

// ============================================================
// Address phase contents
wire [7:0] low_value = (wide || addr_mux_select == 2'h1) ? address[7:0] : {4'h0, address[3:0]};
wire [7:0] high_value = wide ? address[15:8] : {4'h0, address[7:4]};
wire [7:0] upper_value = wide ? {1'b0, address[22:16]} : {4'h0, address[11:8]};

wire [2:0] skip = {3{latch_strobe_style & last_valid}} &
	{(last_upper == upper_value), (last_high == high_value), (last_low == low_value)};

function [2:0] phase_after;
	input [2:0] from;
	input [1:0] mux;
	input [2:0] skp;
	reg   [2:0] s;
	begin
		s = S_DATA;
		if (from < S_UPPER && mux == 2'h3 && !skp[2])
			s = S_UPPER;
		if (from < S_HIGH && mux >= 2'h2 && !skp[1])
			s = S_HIGH;
		if (from < S_LOW && mux >= 2'h1 && !skp[0])
			s = S_LOW;
		phase_after = s;
	end
endfunction

wire start_write = reg_write_in && reg_addr_in == `OFS_WRITE_START && is_master && state == S_IDLE;
wire start_read = reg_write_in && reg_addr_in == `OFS_READ_START && is_master && state == S_IDLE;
wire phase_end = (state != S_IDLE) && (phase_count == 3'h1);
wire master_done = phase_end && state == S_DATA;

// ============================================================
// Host slave access
// buffer index from pins in enhanced mode, from the pointers in buffered mode
wire [1:0] host_read_idx = (slave_port_mode == `MODE_ENHANCED) ? host_addr :
	(slave_port_mode == `MODE_BUFFERED) ? read_ptr : 2'h0;
wire [1:0] host_write_idx = (slave_port_mode == `MODE_ENHANCED) ? host_addr :
	(slave_port_mode == `MODE_BUFFERED) ? write_ptr : 2'h0;
wire slave_active = enabled & ~is_master;
wire read_end = slave_active & host_rd_prev & ~host_rd;
wire write_end = slave_active & host_wr_prev & ~host_wr;

sync2 #(
	.W (13)
) u_sync (
	.clock_in  (clock_in),
	.resetn_in (resetn_in),
	.async_in  ({chip_select_pin_in, read_strobe_pin_in, write_strobe_pin_in,
		address_lines_in, data_lines_in}),
	.sync_out  (synced)
);

// ============================================================
// Control, sequencer and buffers
integer i;
always @(posedge clock_in or negedge resetn_in)
begin
	if (!resetn_in)
	begin
		control_one       <= `CONTROL_RESET;
		port_width_select <= `WIDTH_RESET;
		address           <= 23'h00_0000;
		write_data        <= 8'h00;
		read_capture      <= 8'h00;
		is_read           <= 1'b0;
		state             <= S_IDLE;
		phase_count       <= 3'h0;
		last_low          <= 8'h00;
		last_high         <= 8'h00;
		last_upper        <= 8'h00;
		last_valid        <= 1'b0;
		skip_held         <= 3'b000;
		read_ptr          <= 2'h0;
		write_ptr         <= 2'h0;
		host_rd_prev      <= 1'b0;
		host_wr_prev      <= 1'b0;
		for (i = 0; i < 4; i = i + 1)
		begin
			read_buffer[i]  <= 8'h00;
			write_buffer[i] <= 8'h00;
		end
	end
	else
	begin
		host_rd_prev <= host_rd;
		host_wr_prev <= host_wr;
		if (reg_write_in)
		begin
			if (reg_addr_in == `OFS_CONTROL_ONE)
			begin
				control_one <= reg_wdata_in[15:0] & `CTL_WMASK;
				last_valid  <= 1'b0;
			end
			else if (reg_addr_in == `OFS_WIDTH_CFG)
			begin
				port_width_select <= reg_wdata_in[1:0];
				last_valid        <= 1'b0;
			end
			else if (reg_addr_in == `OFS_ADDRESS)
				address <= reg_wdata_in[22:0];
			else if (reg_addr_in[7:4] == 4'h2 && reg_addr_in[1:0] == 2'h0)
				read_buffer[reg_addr_in[3:2]] <= reg_wdata_in[7:0];
		end
		if (start_write || start_read)
		begin
			if (start_write)
				write_data <= reg_wdata_in[7:0];
			is_read     <= start_read;
			state       <= phase_after(S_IDLE, addr_mux_select, skip);
			phase_count <= `PHASE_CYCLES;
			last_low    <= low_value;
			last_high   <= high_value;
			last_upper  <= upper_value;
			last_valid  <= 1'b1;
			skip_held   <= skip;
		end
		else if (phase_end)
		begin
			if (state == S_DATA)
				state <= S_IDLE;
			else
				state <= phase_after(state, addr_mux_select, skip_held);
			phase_count <= `PHASE_CYCLES;
			if (master_done && is_read)
				read_capture <= wide ? host_data : {4'h0, host_data[3:0]};
		end
		else if (state != S_IDLE)
			phase_count <= phase_count - 3'h1;
		if (write_end)
		begin
			write_buffer[host_write_idx] <= host_data;
			write_ptr <= write_ptr + 2'h1;
		end
		if (read_end)
			read_ptr <= read_ptr + 2'h1;
	end
end

// ============================================================
// Pin values
reg [15:0] next_address_lines;
reg [7:0]  next_data;
reg [7:0]  next_data_oe;
reg [2:0]  next_latch;
reg        next_cs;
reg        next_rd;
reg        next_wr;
always @*
begin
	next_address_lines = 16'h0000;
	next_data          = data_lines_out;
	next_data_oe       = bus_hold_enable ? 8'hFF : 8'h00;
	next_latch         = 3'b000;
	next_cs            = 1'b0;
	next_rd            = 1'b0;
	next_wr            = 1'b0;
	if (is_master && state != S_IDLE)
	begin
		if (addr_mux_select == 2'h0)
			next_address_lines = address[15:0];
		else if (addr_mux_select == 2'h1 || !wide)
			next_address_lines = (addr_mux_select == 2'h3) ?
				{6'h00, address[13:12], 8'h00} : {6'h00, address[9:8], 8'h00};
		if (chip_select_function == 2'h0)
			next_cs = 1'b1;
		else if (chip_select_function == 2'h2)
			next_address_lines[14] = 1'b1;
		case (state)
			S_LOW:
			begin
				next_data    = low_value;
				next_data_oe = (wide || addr_mux_select == 2'h1) ? 8'hFF : 8'h0F;
				next_latch   = 3'b001;
			end
			S_HIGH:
			begin
				next_data    = high_value;
				next_data_oe = wide ? 8'hFF : 8'h0F;
				next_latch   = 3'b010;
			end
			S_UPPER:
			begin
				next_data    = upper_value;
				next_data_oe = wide ? 8'hFF : 8'h0F;
				next_latch   = 3'b100;
			end
			default:
			begin
				next_data    = wide ? write_data : {4'h0, write_data[3:0]};
				next_data_oe = is_read ? 8'h00 : (wide ? 8'hFF : 8'h0F);
				next_rd      = is_read;
				next_wr      = ~is_read;
			end
		endcase
	end
	else if (slave_active && host_rd)
	begin
		next_data    = read_buffer[host_read_idx];
		next_data_oe = 8'hFF;
	end
	else if (!enabled)
		next_data_oe = 8'h00;
end

// ============================================================
// Pin registers
always @(posedge clock_in or negedge resetn_in)
begin
	if (!resetn_in)
	begin
		address_lines_out           <= 16'h0000;
		address_lines_oe_out        <= 1'b0;
		data_lines_out              <= 8'h00;
		data_lines_oe_out           <= 8'h00;
		addr_latch_low_strobe_out   <= 1'b1;
		addr_latch_high_strobe_out  <= 1'b1;
		addr_latch_upper_strobe_out <= 1'b1;
		chip_select_pin_out         <= 1'b0;
		read_strobe_pin_out         <= 1'b0;
		write_strobe_pin_out        <= 1'b0;
		strobe_pins_oe_out          <= 1'b0;
	end
	else
	begin
		address_lines_out           <= next_address_lines;
		address_lines_oe_out        <= is_master;
		data_lines_out              <= next_data;
		data_lines_oe_out           <= next_data_oe;
		addr_latch_low_strobe_out   <= next_latch[0] ~^ latch_strobe_polarity;
		addr_latch_high_strobe_out  <= next_latch[1] ~^ latch_strobe_polarity;
		addr_latch_upper_strobe_out <= next_latch[2] ~^ latch_strobe_polarity;
		chip_select_pin_out         <= next_cs;
		read_strobe_pin_out         <= next_rd;
		write_strobe_pin_out        <= next_wr;
		strobe_pins_oe_out          <= is_master;
	end
end

// ============================================================
// Interrupt events
// buffer 3 or address 11 event
wire slave_end = read_end | write_end;
wire buf3_event = slave_end && (irq_mode_select == 2'h3) &&
	(((slave_port_mode == `MODE_BUFFERED) &&
	((read_end && read_ptr == 2'h3) || (write_end && write_ptr == 2'h3))) ||
	((slave_port_mode == `MODE_ENHANCED) && host_addr == 2'h3));
wire cycle_event = (irq_mode_select == 2'h1) && (master_done || slave_end);
wire [`IRQ_BITS-1:0] irq_status;
wire [`IRQ_BITS-1:0] irq_enable;

irq_block #(
	.N (`IRQ_BITS)
) u_irq (
	.clock_in        (clock_in),
	.resetn_in       (resetn_in),
	.event_in        ({master_done, buf3_event | cycle_event}),
	.clear_write_in  (reg_write_in && reg_addr_in == `OFS_IRQ_CLEAR),
	.enable_write_in (reg_write_in && reg_addr_in == `OFS_IRQ_ENABLE),
	.wdata_in        (reg_wdata_in[`IRQ_BITS-1:0]),
	.status_out      (irq_status),
	.enable_out      (irq_enable),
	.irq_out         (irq_out)
);

// ============================================================
// Register read
always @(posedge clock_in or negedge resetn_in)
begin
	if (!resetn_in)
		reg_rdata_out <= 32'h0000_0000;
	else if (!reg_read_in)
		reg_rdata_out <= 32'h0000_0000;
	else if (reg_addr_in == `OFS_CONTROL_ONE)
		reg_rdata_out <= {16'h0000, control_one};
	else if (reg_addr_in == `OFS_WIDTH_CFG)
		reg_rdata_out <= {30'h0000_0000, port_width_select};
	else if (reg_addr_in == `OFS_ADDRESS)
		reg_rdata_out <= {9'h000, address};
	else if (reg_addr_in == `OFS_READ_DATA)
		reg_rdata_out <= {24'h00_0000, read_capture};
	else if (reg_addr_in == `OFS_STATUS)
		reg_rdata_out <= {31'h0000_0000, state != S_IDLE};
	else if (reg_addr_in[7:4] == 4'h2 && reg_addr_in[1:0] == 2'h0)
		reg_rdata_out <= {24'h00_0000, read_buffer[reg_addr_in[3:2]]};
	else if (reg_addr_in[7:4] == 4'h3 && reg_addr_in[1:0] == 2'h0)
		reg_rdata_out <= {24'h00_0000, write_buffer[reg_addr_in[3:2]]};
	else if (reg_addr_in == `OFS_IRQ_STATUS)
		reg_rdata_out <= {30'h0000_0000, irq_status};
	else if (reg_addr_in == `OFS_IRQ_ENABLE)
		reg_rdata_out <= {30'h0000_0000, irq_enable};
	else
		reg_rdata_out <= 32'h0000_0000;
end

endmodule // parallel_port_addr_mux

`default_nettype wire

/* File: testbench/parallel_port_addr_mux_chk.sv */
// Purpose: Port-level assertions for the parallel port block.
// Assumes: One clock domain; reset asynchronous, active low.
// Notes: Latch polarity is not visible here, so strobes are compared to each other.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Checker
module parallel_port_addr_mux_chk (
	// Clock and reset
	input wire logic        clock_in,
	input wire logic        resetn_in,
	// Watched ports
	input wire logic        reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic [15:0] address_lines_out,
	input wire logic        address_lines_oe_out,
	input wire logic [7:0]  data_lines_out,
	input wire logic [7:0]  data_lines_oe_out,
	input wire logic        addr_latch_low_strobe_out,
	input wire logic        addr_latch_high_strobe_out,
	input wire logic        read_strobe_pin_out,
	input wire logic        write_strobe_pin_out,
	input wire logic        strobe_pins_oe_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);
	wire logic dstb = read_strobe_pin_out | write_strobe_pin_out;
	wire logic lsplit = addr_latch_low_strobe_out != addr_latch_high_strobe_out;
	AST_RDATA_GAP: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0000_0000)
		else $error("read data outside its slot");
	AST_RDWR_EXCL: assert property (!(read_strobe_pin_out && write_strobe_pin_out))
		else $error("read and write strobes together");
	AST_WR_DRIVE: assert property (write_strobe_pin_out |-> data_lines_oe_out inside {8'hff, 8'h0f})
		else $error("write data lines not driven");
	AST_RD_FREE: assert property (read_strobe_pin_out |-> data_lines_oe_out == 8'h00)
		else $error("data lines driven during read");
	AST_DATA_LEN: assert property ($rose(write_strobe_pin_out)
		|-> write_strobe_pin_out [*4] ##1 !write_strobe_pin_out)
		else $error("data phase length wrong");
	AST_LATCH_APART: assert property (lsplit |-> !dstb)
		else $error("latch phase overlaps data phase");
	AST_DATA_STEADY: assert property (write_strobe_pin_out && $past(write_strobe_pin_out)
		|-> $stable(data_lines_out) && $stable(address_lines_out))
		else $error("address or data moved in data phase");
	AST_PINS_MASTER: assert property (dstb |-> strobe_pins_oe_out && address_lines_oe_out)
		else $error("strobe without pin enables");
	AST_IDLE_BUS: assert property (!strobe_pins_oe_out |-> data_lines_oe_out inside {8'h00, 8'hff})
		else $error("partial data enable outside master");
	COV_WRITE: cover property ($rose(write_strobe_pin_out));
	COV_READ: cover property ($rose(read_strobe_pin_out));
	COV_LATCH: cover property (lsplit);
endmodule // parallel_port_addr_mux_chk

bind parallel_port_addr_mux parallel_port_addr_mux_chk chk (.clock_in, .resetn_in, .reg_read_in,
	.reg_rdata_out, .address_lines_out, .address_lines_oe_out, .data_lines_out,
	.data_lines_oe_out, .addr_latch_low_strobe_out, .addr_latch_high_strobe_out,
	.read_strobe_pin_out, .write_strobe_pin_out, .strobe_pins_oe_out);
`default_nettype wire

/* File: testbench/ext_memory_model.sv */
// Purpose: External memory on the far side, plus the host data driver.
// Assumes: Latch strobes active at pol_in, read and write strobes active high; read data depends on the latched low byte.
// Notes: An undriven line shows the inverse of its last level, so stale data never passes.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Model
module ext_memory_model (
	// Clock and pins
	input wire logic        clock_in,
	input wire logic        pol_in,
	input wire logic        lo_in,
	input wire logic        hi_in,
	input wire logic        up_in,
	input wire logic        rd_in,
	input wire logic        wr_in,
	input wire logic [15:0] pins_in,
	input wire logic [7:0]  dout_in,
	input wire logic [7:0]  doe_in,
	input wire logic [7:0]  hdata_in,
	input wire logic        hoe_in,
	// Resolved bus and captures
	output logic     [7:0]  bus_out,
	output logic     [7:0]  cap_lo,
	output logic     [7:0]  cap_hi,
	output logic     [7:0]  cap_up,
	output logic     [7:0]  cap_data,
	output logic     [15:0] cap_pins
);
	logic [7:0] prev = 8'h00;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			bus_out[i] = doe_in[i] ? dout_in[i] : hoe_in ? hdata_in[i]
				: rd_in ? (cap_lo[i] ^ 1'(8'hc3 >> i)) : ~prev[i];
	end
	always @(posedge clock_in)
	begin
		prev <= bus_out;
		if (lo_in == pol_in)
			cap_lo <= bus_out;
		if (hi_in == pol_in)
			cap_hi <= bus_out;
		if (up_in == pol_in)
			cap_up <= bus_out;
		if (wr_in)
		begin
			cap_data <= bus_out;
			cap_pins <= pins_in;
		end
	end
endmodule // ext_memory_model
`default_nettype wire

/* File: testbench/parallel_port_addr_mux_tb_top.sv */
// Purpose: Random self-checking bench for the parallel port block.
// Assumes: Register port answers one cycle after the read strobe.
// Notes: Reads of external memory are only checked where the low byte is latched.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Bench
module parallel_port_addr_mux_tb_top;
	logic clock_in = 0, resetn_in = 0, reg_write_in = 0, reg_read_in = 0;
	logic cs = 0, rds = 0, wrs = 0, hoe = 0, pol = 0, p, bh, w, s, cs_at_write;
	logic [7:0] reg_addr_in = 8'h00, hdata = 8'h00, d, mask;
	logic [31:0] reg_wdata_in = 32'h0000_0000, rv, reg_rdata_out;
	logic [1:0] ha = 2'h0, m, cf, iq;
	logic [15:0] a, al, cpins;
	logic [7:0] dout, doe, bus, clo, chi, cup, cdat;
	logic aoe, lo, hi, up, cso, rdo, wro, soe, irq_out;
	int bad_count = 0, check_count = 0, seed = 32'h6a65, lows = 0, base = 0;
	parallel_port_addr_mux uut (.clock_in(clock_in), .resetn_in(resetn_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .address_lines_out(al),
		.address_lines_oe_out(aoe), .address_lines_in(ha), .data_lines_out(dout),
		.data_lines_oe_out(doe), .data_lines_in(bus), .addr_latch_low_strobe_out(lo),
		.addr_latch_high_strobe_out(hi), .addr_latch_upper_strobe_out(up),
		.chip_select_pin_out(cso), .read_strobe_pin_out(rdo), .write_strobe_pin_out(wro),
		.strobe_pins_oe_out(soe), .chip_select_pin_in(cs), .read_strobe_pin_in(rds),
		.write_strobe_pin_in(wrs), .irq_out(irq_out));
	ext_memory_model mem (.clock_in(clock_in), .pol_in(pol), .lo_in(lo), .hi_in(hi),
		.up_in(up), .rd_in(rdo), .wr_in(wro), .pins_in(al), .dout_in(dout), .doe_in(doe),
		.hdata_in(hdata), .hoe_in(hoe), .bus_out(bus), .cap_lo(clo), .cap_hi(chi),
		.cap_up(cup), .cap_data(cdat), .cap_pins(cpins));
	always @(posedge clock_in)
	begin
		if (lo == pol)
			lows <= lows + 1;
		if (wro)
			cs_at_write <= cso;
	end
	initial
	begin
		forever #2 clock_in = ~clock_in;
	end
	function automatic logic [15:0] exp_pins(input logic [1:0] mx, input logic wd,
		input logic [15:0] ad, input logic [1:0] sel);
		logic [15:0] r;
		r = (mx == 2'h0) ? ad : (mx == 2'h1 || wd) ?
			{6'h00, (mx == 2'h3) ? ad[13:12] : ad[9:8], 8'h00} : 16'h0000;
		if (sel == 2'h2)
			r[14] = 1'b1;
		return r;
	endfunction
	task summarize;
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] v);
		@(posedge clock_in);
		reg_addr_in <= ad;
		reg_wdata_in <= v;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] v);
		@(posedge clock_in);
		reg_addr_in <= ad;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		@(negedge clock_in);
		v = reg_rdata_out;
	endtask
	// Busy must clear within a bounded number of polls.
	task wait_idle;
		for (int i = 0; i < 40; i++)
		begin
			rd(8'h18, rv);
			if (rv[0] === 1'b0)
				return;
		end
		bad_count++;
		summarize;
	endtask
	initial
	begin
		repeat (16) @(posedge clock_in);
		resetn_in <= 1'b1;
		rd(8'h00, rv);
		cmp(rv, 32'h0000_0000);
		rd(8'h7c, rv);
		cmp(rv, 32'h0000_0000);
		for (int k = 0; k < 6; k++)
		begin
			m = (k == 4) ? 2'h3 : (k == 5) ? 2'h2 : (k < 3) ? 2'(k) : 2'h0;
			w = (k == 3 || k == 4);
			s = (k == 5);
			cf = (k == 5) ? 2'h2 : 2'h0;
			iq = (k == 4) ? 2'h1 : 2'h0;
			mask = w ? 8'h0f : 8'hff;
			a = $random(seed);
			d = $random(seed);
			p = $random(seed);
			bh = $random(seed);
			pol <= p;
			wr(8'h04, {31'h0, w});
			wr(8'h00, {16'h0, 1'b1, 2'b00, m, 1'b0, 2'b11, cf, p, s, 1'b0, bh, iq});
			wr(8'h08, {16'h0, a});
			wr(8'h0c, {24'h0, d});
			wait_idle;
			cmp(cpins, exp_pins(m, w, a, cf));
			cmp(cs_at_write, cf == 2'h0);
			cmp(cdat & mask, d & mask);
			if (m == 2'h1)
				cmp(clo, a[7:0]);
			if (m == 2'h2)
				cmp({chi, clo}, a);
			if (m == 2'h3)
				cmp({cup[3:0], chi[3:0], clo[3:0]}, a[11:0]);
			if (m != 2'h0)
			begin
				if (s)
					wr(8'h08, {16'h0, a ^ 16'h5a00});
				base = lows;
				wr(8'h10, 32'h0000_0000);
				wait_idle;
				rd(8'h14, rv);
				cmp(rv, {24'h0, (a[7:0] ^ 8'hc3) & mask});
				if (s)
				begin
					cmp(lows - base, 0);
					cmp(chi, a[15:8] ^ 8'h5a);
				end
			end
			rd(8'h40, rv);
			cmp(rv, {30'h0, 1'b1, k == 4});
			cmp(irq_out, k != 0);
			if (k == 0)
				wr(8'h48, 32'h0000_0002);
			wr(8'h44, 32'h0000_0003);
			@(negedge clock_in);
			cmp(irq_out, 1'b0);
		end
		wr(8'h00, 32'h0000_8203);
		wr(8'h48, 32'h0000_0001);
		wr(8'h2c, {24'h0, d});
		@(posedge clock_in);
		ha <= 2'h3;
		cs <= 1'b1;
		rds <= 1'b1;
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		cmp(bus, d);
		@(posedge clock_in);
		cs <= 1'b0;
		rds <= 1'b0;
		repeat (4) @(posedge clock_in);
		rd(8'h40, rv);
		cmp(rv, 32'h0000_0001);
		wr(8'h44, 32'h0000_0001);
		@(posedge clock_in);
		hdata <= d ^ 8'h99;
		hoe <= 1'b1;
		cs <= 1'b1;
		wrs <= 1'b1;
		repeat (6) @(posedge clock_in);
		cs <= 1'b0;
		wrs <= 1'b0;
		repeat (3) @(posedge clock_in);
		hoe <= 1'b0;
		repeat (4) @(posedge clock_in);
		rd(8'h3c, rv);
		cmp(rv, {24'h0, d ^ 8'h99});
		cmp(irq_out, 1'b1);
		summarize;
	end
endmodule // parallel_port_addr_mux_tb_top
`default_nettype wire
